// file: rtl/hbcc_defs.svh
// timing and encoding constants for the h-bridge chopper control
`ifndef HBCC_DEFS_SVH
`define HBCC_DEFS_SVH
`define HBCC_CLK_MHZ 100
`define HBCC_CHOP_OFF_US 35
`define HBCC_BLANK_US 5
`define HBCC_OCP_OFF_US 142
`define HBCC_OCP_ON_US 5
`define HBCC_DIAG_KHZ 90
`define HBCC_DEAD_NS 150
`define HBCC_CHOP_OFF_CYC (`HBCC_CHOP_OFF_US * `HBCC_CLK_MHZ)
`define HBCC_BLANK_CYC (`HBCC_BLANK_US * `HBCC_CLK_MHZ)
`define HBCC_OCP_OFF_CYC (`HBCC_OCP_OFF_US * `HBCC_CLK_MHZ)
`define HBCC_OCP_ON_CYC (`HBCC_OCP_ON_US * `HBCC_CLK_MHZ)
`define HBCC_DIAG_HALF_CYC ((`HBCC_CLK_MHZ * 1000) / (2 * `HBCC_DIAG_KHZ))
`define HBCC_DEAD_CYC ((`HBCC_DEAD_NS * `HBCC_CLK_MHZ + 999) / 1000)
`define HBCC_FILT_CYC 100
`define HBCC_CNT_W 16
`define HBCC_DEAD_W 8
`define HBCC_CNT_ZERO 16'h0000
`define HBCC_CNT_ONE 16'h0001
`define HBCC_DEAD_ZERO 8'h00
`define HBCC_DEAD_ONE 8'h01
`endif

// file: rtl/hbcc_pkg.sv
// types shared by the h-bridge chopper control
package hbcc_pkg;
  typedef enum logic [1:0] {
    HBCC_COAST,
    HBCC_FWD,
    HBCC_REV,
    HBCC_BRAKE
  } hbcc_mode_e;
  // gate enables of the four switches
  typedef struct packed {
    logic hs_a;
    logic ls_a;
    logic hs_b;
    logic ls_b;
  } hbcc_gates_s;
  // fault detector levels
  typedef struct packed {
    logic uv_main;
    logic uv_logic;
    logic uv_pump;
    logic thermal_shutdown;
  } hbcc_faults_s;
endpackage

// file: rtl/hbcc_in_filter.sv
// glitch filter for one asynchronous direction input
`include "hbcc_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module hbcc_in_filter (
  input wire logic clock,
  input wire logic rst,
  input wire logic pin,
  output logic level
);
  logic s1_reg, s2_reg, s3_reg;
  logic [`HBCC_CNT_W-1:0] cnt_reg, cnt_next;
  logic level_reg, level_next;

  // three-stage sync; s1 is read only by s2
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      cnt_reg <= `HBCC_CNT_ZERO;
      level_reg <= 1'b0;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      cnt_reg <= cnt_next;
      level_reg <= level_next;
    end
  end

  // low-pass: new level must hold a full window
  always_comb begin
    cnt_next = `HBCC_CNT_ZERO;
    level_next = level_reg;
    if (s2_reg == s3_reg && s3_reg != level_reg) begin
      if (cnt_reg == 16'(`HBCC_FILT_CYC - 1)) begin
        level_next = s3_reg;
      end else begin
        cnt_next = cnt_reg + `HBCC_CNT_ONE;
      end
    end
  end

  assign level = level_reg;
endmodule // hbcc_in_filter
`default_nettype wire

// file: rtl/hbcc_top.sv
// h-bridge mode decode, current chopper, fault gating and diag output
`include "hbcc_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module hbcc_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic dir_input_a,
  input wire logic dir_input_b,
  input wire logic limit_cmp,
  input wire logic overcurrent_cmp,
  input wire hbcc_pkg::hbcc_faults_s faults,
  output hbcc_pkg::hbcc_gates_s gates,
  output logic diag
);
  import hbcc_pkg::*;

  logic dir_a, dir_b;
  logic lim_s1_reg, lim_s2_reg, lim_s3_reg, lim_reg, lim_next;
  logic oc_s1_reg, oc_s2_reg, oc_s3_reg, oc_reg, oc_next;
  hbcc_faults_s f_s1_reg, f_s2_reg, f_s3_reg, f_reg, f_next;
  hbcc_mode_e mode;
  logic fault_off;
  logic [`HBCC_CNT_W-1:0] blank_reg, blank_next;
  logic [`HBCC_CNT_W-1:0] chop_reg, chop_next;
  logic [`HBCC_CNT_W-1:0] ocp_reg, ocp_next;
  logic [`HBCC_CNT_W-1:0] ocpon_reg, ocpon_next;
  logic [`HBCC_CNT_W-1:0] dpulse_reg, dpulse_next;
  logic dtog_reg, dtog_next;
  logic [`HBCC_DEAD_W-1:0] dead_reg, dead_next;
  hbcc_gates_s want, gates_reg, gates_next;
  logic diag_reg, diag_next;
  logic drive_on;

  // direction input filters
  hbcc_in_filter u_filt_a (
    .clock(clock),
    .rst(rst),
    .pin(dir_input_a),
    .level(dir_a)
  );
  hbcc_in_filter u_filt_b (
    .clock(clock),
    .rst(rst),
    .pin(dir_input_b),
    .level(dir_b)
  );

  // comparators and detectors are asynchronous: three-stage sync
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lim_s1_reg <= 1'b0;
      lim_s2_reg <= 1'b0;
      lim_s3_reg <= 1'b0;
      lim_reg <= 1'b0;
      oc_s1_reg <= 1'b0;
      oc_s2_reg <= 1'b0;
      oc_s3_reg <= 1'b0;
      oc_reg <= 1'b0;
      f_s1_reg <= '0;
      f_s2_reg <= '0;
      f_s3_reg <= '0;
      f_reg <= '0;
    end else begin
      lim_s1_reg <= limit_cmp;
      lim_s2_reg <= lim_s1_reg;
      lim_s3_reg <= lim_s2_reg;
      lim_reg <= lim_next;
      oc_s1_reg <= overcurrent_cmp;
      oc_s2_reg <= oc_s1_reg;
      oc_s3_reg <= oc_s2_reg;
      oc_reg <= oc_next;
      f_s1_reg <= faults;
      f_s2_reg <= f_s1_reg;
      f_s3_reg <= f_s2_reg;
      f_reg <= f_next;
    end
  end

  // accept a change once stages two and three agree
  always_comb begin
    lim_next = (lim_s2_reg == lim_s3_reg) ? lim_s3_reg : lim_reg;
    oc_next = (oc_s2_reg == oc_s3_reg) ? oc_s3_reg : oc_reg;
    f_next = f_reg;
    for (int i = 0; i < 4; i++) begin
      if (f_s2_reg[i] == f_s3_reg[i]) begin
        f_next[i] = f_s3_reg[i];
      end
    end
  end

  // mode decode from filtered inputs
  always_comb begin
    case ({dir_a, dir_b})
      2'b00: mode = HBCC_COAST;
      2'b10: mode = HBCC_FWD;
      2'b01: mode = HBCC_REV;
      2'b11: mode = HBCC_BRAKE;
      default: mode = HBCC_COAST;
    endcase
  end

  // uv and thermal levels gate the gates, chopper and diag; the overcurrent timer still runs
  // thermal off follows the level, so recovery is automatic
  assign fault_off = |f_reg;
  assign drive_on = (mode == HBCC_FWD || mode == HBCC_REV) && !fault_off;

  // chopper and overcurrent timers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      blank_reg <= `HBCC_CNT_ZERO;
      chop_reg <= `HBCC_CNT_ZERO;
      ocp_reg <= `HBCC_CNT_ZERO;
      ocpon_reg <= `HBCC_CNT_ZERO;
    end else begin
      blank_reg <= blank_next;
      chop_reg <= chop_next;
      ocp_reg <= ocp_next;
      ocpon_reg <= ocpon_next;
    end
  end

  // counters loaded from derived cycle counts
  always_comb begin
    blank_next = blank_reg;
    chop_next = chop_reg;
    ocp_next = ocp_reg;
    ocpon_next = ocpon_reg;
    if (ocp_reg != `HBCC_CNT_ZERO) begin
      ocp_next = ocp_reg - `HBCC_CNT_ONE;
      if (ocp_reg == `HBCC_CNT_ONE) begin
        ocpon_next = 16'(`HBCC_OCP_ON_CYC);
      end
    end else if (ocpon_reg != `HBCC_CNT_ZERO) begin
      ocpon_next = ocpon_reg - `HBCC_CNT_ONE;
    end else if (oc_reg) begin
      // all off for the overcurrent off-time, not latched
      ocp_next = 16'(`HBCC_OCP_OFF_CYC);
      chop_next = `HBCC_CNT_ZERO;
    end
    // overcurrent off-time counts as drive off, so blanking restarts after it
    if (!drive_on || ocp_reg != `HBCC_CNT_ZERO) begin
      chop_next = `HBCC_CNT_ZERO;
      blank_next = 16'(`HBCC_BLANK_CYC);
    end else if (chop_reg != `HBCC_CNT_ZERO) begin
      chop_next = chop_reg - `HBCC_CNT_ONE;
      if (chop_reg == `HBCC_CNT_ONE) begin
        blank_next = 16'(`HBCC_BLANK_CYC);
      end
    end else if (blank_reg != `HBCC_CNT_ZERO) begin
      blank_next = blank_reg - `HBCC_CNT_ONE;
    end else if (lim_reg && ocp_reg == `HBCC_CNT_ZERO) begin
      chop_next = 16'(`HBCC_CHOP_OFF_CYC);
    end
  end

  // wanted gates before dead time
  always_comb begin
    want = '0;
    if (!fault_off && ocp_reg == `HBCC_CNT_ZERO) begin
      case (mode)
        HBCC_COAST: want = '0;
        HBCC_FWD: begin
          want.hs_a = (chop_reg == `HBCC_CNT_ZERO);
          want.ls_b = 1'b1;
        end
        HBCC_REV: begin
          want.hs_b = (chop_reg == `HBCC_CNT_ZERO);
          want.ls_a = 1'b1;
        end
        HBCC_BRAKE: begin
          want.ls_a = 1'b1;
          want.ls_b = 1'b1;
        end
        default: want = '0;
      endcase
    end
  end

  // dead time and gate registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dead_reg <= `HBCC_DEAD_ZERO;
      gates_reg <= '0;
    end else begin
      dead_reg <= dead_next;
      gates_reg <= gates_next;
    end
  end

  // turn-offs pass at once; turn-ons wait the dead time
  always_comb begin
    gates_next = gates_reg & want;
    dead_next = dead_reg;
    if ((gates_reg & ~want) != '0) begin
      dead_next = 8'(`HBCC_DEAD_CYC);
    end else if (dead_reg != `HBCC_DEAD_ZERO) begin
      dead_next = dead_reg - `HBCC_DEAD_ONE;
    end else begin
      gates_next = want;
    end
  end

  assign gates = gates_reg;

  // free-running diag pulse timer and output
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dpulse_reg <= `HBCC_CNT_ZERO;
      dtog_reg <= 1'b0;
      diag_reg <= 1'b0;
    end else begin
      dpulse_reg <= dpulse_next;
      dtog_reg <= dtog_next;
      diag_reg <= diag_next;
    end
  end

  // toggle runs always, never synced to chopper edges
  always_comb begin
    dpulse_next = dpulse_reg + `HBCC_CNT_ONE;
    dtog_next = dtog_reg;
    if (dpulse_reg == 16'(`HBCC_DIAG_HALF_CYC - 1)) begin
      dpulse_next = `HBCC_CNT_ZERO;
      dtog_next = ~dtog_reg;
    end
    // low on any fault or overcurrent off-time, toggles in chopper off-time, else high
    if (fault_off || ocp_reg != `HBCC_CNT_ZERO) begin
      diag_next = 1'b0;
    end else if (chop_reg != `HBCC_CNT_ZERO) begin
      diag_next = dtog_reg;
    end else begin
      diag_next = 1'b1;
    end
  end

  assign diag = diag_reg;

  // checks
  // high and low side of one leg never on together
  AST_NO_SHOOT: assert property (@(posedge clock) disable iff (rst)
    !(gates.hs_a && gates.ls_a) && !(gates.hs_b && gates.ls_b))
    else $error("leg shoot-through");
  AST_FAULT_OFF: assert property (@(posedge clock) disable iff (rst)
    fault_off |=> gates == '0)
    else $error("gates on during fault");
  AST_OCP_OFF: assert property (@(posedge clock) disable iff (rst)
    ocp_reg != `HBCC_CNT_ZERO |=> gates == '0)
    else $error("gates on during overcurrent off-time");
  AST_DIAG_LOW: assert property (@(posedge clock) disable iff (rst)
    fault_off |=> !diag)
    else $error("diag not low on fault");
  AST_CHOP_HS: assert property (@(posedge clock) disable iff (rst)
    chop_reg > `HBCC_CNT_ONE |=> !gates.hs_a && !gates.hs_b)
    else $error("high side on in chopper off-time");
  AST_CHOP_LEN: assert property (@(posedge clock) disable iff (rst)
    $rose(chop_reg != `HBCC_CNT_ZERO) && drive_on && !oc_reg
      |-> (chop_reg != `HBCC_CNT_ZERO)[*8])
    else $error("chopper off-time too short");
  AST_BLANK: assert property (@(posedge clock) disable iff (rst)
    blank_reg != `HBCC_CNT_ZERO && chop_reg == `HBCC_CNT_ZERO && drive_on
      |=> chop_reg == `HBCC_CNT_ZERO)
    else $error("limit acted during blanking");
  AST_DEAD: assert property (@(posedge clock) disable iff (rst)
    $fell(gates.ls_a) |=> !gates.hs_a [*2])
    else $error("dead time too short");
  AST_BRAKE: assert property (@(posedge clock) disable iff (rst)
    mode == HBCC_BRAKE && !fault_off && ocp_reg == `HBCC_CNT_ZERO
      |-> ##[1:20] gates.ls_a && gates.ls_b)
    else $error("brake not applied");
  AST_OCP_START: assert property (@(posedge clock) disable iff (rst)
    oc_reg && ocp_reg == `HBCC_CNT_ZERO && ocpon_reg == `HBCC_CNT_ZERO
      |=> ocp_reg == 16'(`HBCC_OCP_OFF_CYC))
    else $error("overcurrent off-time not loaded");
  CV_FWD: cover property (@(posedge clock) disable iff (rst) gates.hs_a && gates.ls_b);
  CV_CHOP: cover property (@(posedge clock) disable iff (rst) $rose(chop_reg != `HBCC_CNT_ZERO));
  CV_OCP: cover property (@(posedge clock) disable iff (rst) $rose(ocp_reg != `HBCC_CNT_ZERO));
  CV_FAULT: cover property (@(posedge clock) disable iff (rst) $fell(fault_off));
endmodule // hbcc_top
`default_nettype wire

// file: dv/hbcc_host_model.sv
// host model: drives the direction pins and can inject noise on pin b
`timescale 1ns/1ns
`default_nettype none
module hbcc_host_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] want,
  input wire logic glitch,
  output logic dir_input_a,
  output logic dir_input_b
);
  logic [1:0] dir_reg;
  logic [9:0] hold_reg;
  // rate limit
  // each level stands 500 cycles (5 us), so apart from glitch no pin toggles above 100 kHz
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dir_reg <= 2'h0;
      hold_reg <= 10'h1f4;
    end else if (want != dir_reg && hold_reg >= 10'h1f4) begin
      dir_reg <= want;
      hold_reg <= 10'h000;
    end else if (hold_reg < 10'h1f4) begin
      hold_reg <= hold_reg + 10'h001;
    end
  end
  // glitch is only raised by the noise scenario
  assign dir_input_a = dir_reg[1];
  assign dir_input_b = dir_reg[0] ^ glitch;
endmodule // hbcc_host_model
`default_nettype wire

// file: dv/hbcc_top_bench.sv
// self-checking bench for the h-bridge chopper control
`timescale 1ns/1ns
`default_nettype none
module hbcc_top_bench;
  import hbcc_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [1:0] want = 2'h0;
  logic glitch = 1'b0;
  logic limit_cmp = 1'b0;
  logic overcurrent_cmp = 1'b0;
  hbcc_faults_s faults = '0;
  wire logic dir_input_a;
  wire logic dir_input_b;
  hbcc_gates_s gates;
  logic diag;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  // gate table
  // nibble per {a,b}: coast 0, reverse 6, forward 9, brake 5
  localparam logic [15:0] GTAB = 16'h5960;

  hbcc_top u_dut (.clock(clock), .rst(rst), .dir_input_a(dir_input_a), .dir_input_b(dir_input_b),
    .limit_cmp(limit_cmp), .overcurrent_cmp(overcurrent_cmp), .faults(faults), .gates(gates), .diag(diag));
  hbcc_host_model u_host (.clock(clock), .rst(rst), .want(want), .glitch(glitch),
    .dir_input_a(dir_input_a), .dir_input_b(dir_input_b));

  // clock and hang guard, the whole run needs well under 100k cycles
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 100000) begin
      miscompares++;
      results();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // sampling on the falling edge keeps clear of the design's own updates
  task automatic wait_g(input logic [3:0] exp, input int lim);
    int i;
    @(negedge clock);
    for (i = 0; i < lim && gates !== exp; i++) @(negedge clock);
  endtask

  // counts cycles while the masked gates keep a value
  task automatic hold_n(input logic [3:0] mask, input logic [3:0] val, output int n);
    n = 0;
    @(negedge clock);
    while ((gates & mask) === val && n < 20000) begin
      @(negedge clock);
      n++;
    end
  endtask

  task automatic set_mode(input logic [1:0] m);
    @(posedge clock);
    want <= m;
    wait_g(GTAB[m*4 +: 4], 3000);
  endtask

  task automatic t_modes();
    int m;
    for (m = 0; m < 4; m++) begin
      set_mode(m[1:0]);
      check(16'(gates), 16'(GTAB[m*4 +: 4]));
    end
    $display("test modes done");
  endtask

  task automatic t_dead();
    int t;
    int off_t;
    int on_t;
    off_t = -1;
    on_t = -1;
    set_mode(2'h2);
    check(16'(diag), 16'h1);
    @(posedge clock);
    want <= 2'h1;
    for (t = 0; t < 3000 && on_t < 0; t++) begin
      @(negedge clock);
      if (off_t < 0 && gates.hs_a === 1'b0) off_t = t;
      if (on_t < 0 && gates.ls_a === 1'b1) on_t = t;
    end
    check(16'(on_t - off_t >= 15 && on_t - off_t <= 75), 16'h1);
    $display("test dead time done");
  endtask

  task automatic t_glitch();
    logic bad;
    bad = 1'b0;
    set_mode(2'h2);
    @(posedge clock);
    glitch <= 1'b1;
    repeat (20) @(posedge clock);
    glitch <= 1'b0;
    repeat (300) begin
      @(negedge clock);
      bad |= (gates !== 4'h9);
    end
    check(16'(bad), 16'h0);
    $display("test noise filter done");
  endtask

  task automatic t_chop();
    int n;
    int tog;
    logic prev;
    repeat (600) @(posedge clock);
    limit_cmp <= 1'b1;
    repeat (5) @(posedge clock);
    limit_cmp <= 1'b0;
    hold_n(4'h8, 4'h8, n);
    check(16'(n < 20), 16'h1);
    check(16'(gates), 16'h1);
    n = 0;
    tog = 0;
    prev = diag;
    while (gates.hs_a === 1'b0 && n < 5000) begin
      @(negedge clock);
      n++;
      tog += int'(diag !== prev);
      prev = diag;
    end
    check(16'(n >= 3495 && n <= 3520), 16'h1);
    check(16'(tog >= 5), 16'h1);
    check(16'(tog <= 8), 16'h1);
    check(16'(gates), 16'h9);
    @(posedge clock);
    limit_cmp <= 1'b1;
    hold_n(4'h8, 4'h8, n);
    check(16'(n >= 495 && n <= 520), 16'h1);
    @(posedge clock);
    limit_cmp <= 1'b0;
    wait_g(4'h9, 4000);
    $display("test chopper done");
  endtask

  task automatic t_ocp();
    int n;
    @(posedge clock);
    overcurrent_cmp <= 1'b1;
    repeat (5) @(posedge clock);
    overcurrent_cmp <= 1'b0;
    wait_g(4'h0, 20);
    check(16'(diag), 16'h0);
    hold_n(4'hf, 4'h0, n);
    check(16'(n >= 14195 && n <= 14230), 16'h1);
    check(16'(gates), 16'h9);
    @(posedge clock);
    overcurrent_cmp <= 1'b1;
    hold_n(4'hf, 4'h9, n);
    check(16'(n >= 480 && n <= 530), 16'h1);
    @(posedge clock);
    overcurrent_cmp <= 1'b0;
    wait_g(4'h9, 16000);
    $display("test overcurrent done");
  endtask

  task automatic t_faults();
    int i;
    for (i = 0; i < 4; i++) begin
      @(posedge clock);
      faults <= hbcc_faults_s'(4'h1 << i);
      wait_g(4'h0, 20);
      check(16'(gates), 16'h0);
      check(16'(diag), 16'h0);
      @(posedge clock);
      faults <= '0;
      wait_g(4'h9, 3000);
      check(16'(gates), 16'h9);
      check(16'(diag), 16'h1);
    end
    $display("test faults done");
  endtask

  // main sequence after a 20-cycle reset
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_modes();
    t_dead();
    t_glitch();
    t_chop();
    t_ocp();
    t_faults();
    results();
  end
endmodule // hbcc_top_bench
`default_nettype wire
